// ### mtr_translation_regs.sv
// Register front end of the interrupt translation service.
// Assumes a single-cycle register port and mapping updates from same-clock logic.
//
// Contract
// - Identification word: product, zeros, variant, revision, implementer
// - Implementer: continuation nibble, bit7 zero, identity code
// - Identification register single, shared by security states
// - 16-bit translate writes zero the upper half
// - Drop translate writes while service disabled
// - Drop writes from unmapped requester
// - Drop writes whose requester exceeds implemented width
// - Drop writes whose event exceeds mapped range
// - Drop writes whose in-range event is unmapped
// - Whole data word is the event tag
// - Requester tag indexes the device table
// - Translate register at shared set-interrupt offset
// - Bit 36 flags collection width field validity
// - Bits 35:32 give collection bits minus one
// - Hardware collection count; collections unmapped at reset
// - Bit 19 selects target address format
// - Bit 18 reports local system error support
// - Requester and event widths minus one
// - Bits 7:4 give entry bytes minus one
// - Bit 1 virtual support, bit 0 one
// - Control bit 0 enables service, resets zero
`timescale 1ns/1ps
`include "mtr_cfg.svh"

module mtr_translation_regs #(
  parameter int unsigned DEV_BITS      = 4,
  parameter int unsigned EVT_BITS      = 4,
  parameter logic [7:0]  HW_COLL_COUNT = 8'h04,
  parameter logic        COLL_LIMIT    = 1'b1,
  parameter logic [3:0]  COLL_WIDTH_M1 = 4'h3,
  parameter logic        TARGET_FMT    = 1'b0,
  parameter logic        LOCAL_SYSERR  = 1'b0,
  parameter logic        VIRT          = 1'b0,
  parameter logic [3:0]  ENTRY_M1      = 4'h7
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [15:0]          reg_addr,
  input  wire mtr_pkg::mtr_size_type reg_size,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic [31:0]          requester_tag,
  output logic [31:0]               reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic                 map_dev_wr,
  input  wire logic [DEV_BITS-1:0]  map_dev_id,
  input  wire logic                 map_dev_valid,
  input  wire logic [4:0]           map_dev_range_m1,
  input  wire logic                 map_evt_wr,
  input  wire logic [DEV_BITS-1:0]  map_evt_dev,
  input  wire logic [EVT_BITS-1:0]  map_evt_id,
  input  wire logic                 map_evt_valid,
  output logic                      xlate_valid,
  output logic [DEV_BITS-1:0]       xlate_requester,
  output logic [31:0]               xlate_event,
  output logic                      xlate_drop,
  output logic                      service_enabled
);
  localparam int unsigned NDEV = 1 << DEV_BITS;
  localparam int unsigned NEVT = 1 << EVT_BITS;
  localparam logic [4:0]  DEV_M1 = 5'(DEV_BITS - 1);
  localparam logic [4:0]  EVT_M1 = 5'(EVT_BITS - 1);

  // Fixed read-only images; one copy serves both security states
  wire logic [31:0] impl_id_w = {`MTR_PRODUCT_CODE, 4'h0, `MTR_VARIANT, `MTR_REVISION,
                                 `MTR_CONT_CODE, 1'b0, `MTR_MAKER_CODE};
  wire logic [63:0] feature_w = {27'h0, COLL_LIMIT, COLL_WIDTH_M1,
                                 HW_COLL_COUNT, 4'h0,
                                 TARGET_FMT, LOCAL_SYSERR,
                                 DEV_M1, EVT_M1,
                                 ENTRY_M1, 1'b0, 1'b0, VIRT, 1'b1};

  logic                     enable_q, enable_d;
  logic [14:0]              cwr_q, cwr_d;
  logic [31:0]              rdata_q, rdata_d;
  logic                     rvalid_q, rvalid_d;
  logic                     xv_q, xv_d, xd_q, xd_d;
  logic [DEV_BITS-1:0]      xr_q, xr_d;
  logic [31:0]              xe_q, xe_d;
  logic [NDEV-1:0]          dev_valid_q, dev_valid_d;
  logic [4:0]               dev_range_q [NDEV];
  logic [4:0]               dev_range_d [NDEV];
  logic [NEVT-1:0]          evt_map_q [NDEV];
  logic [NEVT-1:0]          evt_map_d [NDEV];

  // Translate request decode; write-only, reads return zero
  logic                     is_xlate;
  logic [31:0]              evt_word;
  logic                     req_in_range, dev_ok, evt_in_range, evt_ok, accept;
  logic [DEV_BITS-1:0]      req_idx;
  logic [EVT_BITS-1:0]      evt_idx;

  always_comb begin
    is_xlate = reg_wr && (reg_addr == `MTR_OFF_TRANSLATE);
    // Half-word write carries only the low sixteen bits
    evt_word = (reg_size == mtr_pkg::MTR_SZ16) ? {16'h0000, reg_wdata[15:0]} : reg_wdata;
    // Tag is trusted as delivered by the interconnect
    req_in_range = (requester_tag >> DEV_BITS) == 32'h0;
    req_idx = requester_tag[DEV_BITS-1:0];
    dev_ok = req_in_range && dev_valid_q[req_idx];
    // Range check against the width fixed at mapping
    evt_in_range = (evt_word >> ({27'h0, dev_range_q[req_idx]} + 32'h1)) == 32'h0;
    evt_in_range = evt_in_range && ((evt_word >> EVT_BITS) == 32'h0);
    evt_idx = evt_word[EVT_BITS-1:0];
    evt_ok = evt_in_range && evt_map_q[req_idx][evt_idx];
    accept = enable_q && dev_ok && evt_ok;
  end

  // Register writes, read answers and translation outputs
  always_comb begin
    enable_d = enable_q;
    cwr_d    = cwr_q;
    rdata_d  = rdata_q;
    rvalid_d = reg_rd;
    xv_d     = is_xlate && accept;
    xd_d     = is_xlate && !accept;
    xr_d     = is_xlate ? req_idx : xr_q;
    xe_d     = is_xlate ? evt_word : xe_q;
    // Only the enable bit of control is writable
    if (reg_wr && reg_addr == `MTR_OFF_CONTROL) begin
      enable_d = reg_wdata[`MTR_CTRL_ENABLE_BIT];
    end
    if (reg_wr && reg_addr == `MTR_OFF_CWR_LO) begin
      cwr_d = reg_wdata[`MTR_CWR_MSB:`MTR_CWR_LSB];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `MTR_OFF_CONTROL: rdata_d = {31'h0, enable_q};
        `MTR_OFF_IMPL_ID: rdata_d = impl_id_w;
        `MTR_OFF_FEAT_LO: rdata_d = feature_w[31:0];
        `MTR_OFF_FEAT_HI: rdata_d = feature_w[63:32];
        `MTR_OFF_CWR_LO:  rdata_d = {12'h000, cwr_q, 5'h00};
        default:          rdata_d = 32'h0; // Unmapped and write-only read zero
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= `MTR_CTRL_RESET;
      cwr_q    <= `MTR_CWR_RESET;
      rdata_q  <= 32'h0;
      rvalid_q <= 1'b0;
      xv_q     <= 1'b0;
      xd_q     <= 1'b0;
      xr_q     <= '0;
      xe_q     <= 32'h0;
    end else begin
      enable_q <= enable_d;
      cwr_q    <= cwr_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      xv_q     <= xv_d;
      xd_q     <= xd_d;
      xr_q     <= xr_d;
      xe_q     <= xe_d;
    end
  end

  // Mapping tables; everything starts unmapped so no stale entry can translate
  always_comb begin
    dev_valid_d = dev_valid_q;
    dev_range_d = dev_range_q;
    evt_map_d   = evt_map_q;
    if (map_dev_wr) begin
      dev_valid_d[map_dev_id] = map_dev_valid;
      dev_range_d[map_dev_id] = map_dev_range_m1;
      // Remapping a requester wipes its event entries
      evt_map_d[map_dev_id]   = '0;
    end
    if (map_evt_wr) begin
      evt_map_d[map_evt_dev][map_evt_id] = map_evt_valid;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_valid_q <= '0;
      for (int i = 0; i < NDEV; i++) begin
        dev_range_q[i] <= 5'h00;
        evt_map_q[i]   <= '0;
      end
    end else begin
      dev_valid_q <= dev_valid_d;
      dev_range_q <= dev_range_d;
      evt_map_q   <= evt_map_d;
    end
  end

  assign reg_rdata       = rdata_q;
  assign reg_rvalid      = rvalid_q;
  assign xlate_valid     = xv_q;
  assign xlate_drop      = xd_q;
  assign xlate_requester = xr_q;
  assign xlate_event     = xe_q;
  assign service_enabled = enable_q;

  // Checks beside the logic
  property p_no_xlate_disabled;
    @(posedge sys_clk) disable iff (!rst_n)
      (is_xlate && !enable_q) |=> (xlate_drop && !xlate_valid);
  endproperty
  a_no_xlate_disabled: assert property (p_no_xlate_disabled)
    else $error("translate accepted while disabled");

  property p_req_range;
    @(posedge sys_clk) disable iff (!rst_n)
      (is_xlate && !req_in_range) |=> xlate_drop;
  endproperty
  a_req_range: assert property (p_req_range)
    else $error("oversized requester not dropped");

  property p_unmapped_dev;
    @(posedge sys_clk) disable iff (!rst_n)
      (is_xlate && req_in_range && !dev_valid_q[req_idx]) |=> xlate_drop;
  endproperty
  a_unmapped_dev: assert property (p_unmapped_dev)
    else $error("unmapped requester not dropped");

  property p_half_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (is_xlate && reg_size == mtr_pkg::MTR_SZ16) |=> (xlate_event[31:16] == 16'h0000);
  endproperty
  a_half_write: assert property (p_half_write)
    else $error("half write kept upper bits");

  sequence s_id_read;
    reg_rd && reg_addr == `MTR_OFF_IMPL_ID;
  endsequence
  property p_id_read;
    @(posedge sys_clk) disable iff (!rst_n)
      s_id_read |=> (reg_rvalid && reg_rdata[7] == 1'b0 && reg_rdata[23:20] == 4'h0);
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identification reserved bits not zero");

  property p_feat_phys;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `MTR_OFF_FEAT_LO) |=> (reg_rdata[0] && reg_rdata[3:2] == 2'b00);
  endproperty
  a_feat_phys: assert property (p_feat_phys)
    else $error("physical support bit not one");

  property p_feat_hi;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `MTR_OFF_FEAT_HI) |=> (reg_rdata[31:5] == 27'h0);
  endproperty
  a_feat_hi: assert property (p_feat_hi)
    else $error("feature upper reserved bits set");

  property p_enable_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == `MTR_OFF_CONTROL) |=> (service_enabled == $past(reg_wdata[0]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable bit did not follow write");

  property p_accept_cause;
    @(posedge sys_clk) disable iff (!rst_n)
      xlate_valid |-> $past(is_xlate && enable_q && dev_ok && evt_ok);
  endproperty
  a_accept_cause: assert property (p_accept_cause)
    else $error("translation without valid cause");

  // Every translate write gets exactly one verdict carrying its event
  sequence s_xlate_req;
    is_xlate;
  endsequence
  property p_xlate_event;
    @(posedge sys_clk) disable iff (!rst_n)
      s_xlate_req |=> ((xlate_valid ^ xlate_drop) && xlate_event == $past(evt_word));
  endproperty
  a_xlate_event: assert property (p_xlate_event)
    else $error("translate verdict or event wrong");

  // Other offsets must never raise a verdict
  property p_no_spurious;
    @(posedge sys_clk) disable iff (!rst_n)
      !is_xlate |=> (!xlate_valid && !xlate_drop);
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("verdict without translate write");

  property p_evt_range;
    @(posedge sys_clk) disable iff (!rst_n)
      (is_xlate && dev_ok && !evt_in_range) |=> xlate_drop;
  endproperty
  a_evt_range: assert property (p_evt_range)
    else $error("out of range event not dropped");

  property p_evt_unmapped;
    @(posedge sys_clk) disable iff (!rst_n)
      (is_xlate && evt_in_range && !evt_map_q[req_idx][evt_idx]) |=> xlate_drop;
  endproperty
  a_evt_unmapped: assert property (p_evt_unmapped)
    else $error("unmapped event not dropped");

  // Identification word is always answered, whatever the configuration
  property p_id_present;
    @(posedge sys_clk) disable iff (!rst_n)
      s_id_read |=> (reg_rvalid && reg_rdata[31:24] == `MTR_PRODUCT_CODE);
  endproperty
  a_id_present: assert property (p_id_present)
    else $error("identification word not answered");
endmodule

// ### mtr_cfg.svh
// Offsets, field positions, reset values and fixed codes of the translation front end.
// Assumes byte addresses on the register port; 64-bit registers as two words.
`ifndef MTR_CFG_SVH
`define MTR_CFG_SVH

`define MTR_OFF_CONTROL   16'h0000
`define MTR_OFF_IMPL_ID   16'h0004
`define MTR_OFF_FEAT_LO   16'h0008
`define MTR_OFF_FEAT_HI   16'h000C
`define MTR_OFF_TRANSLATE 16'h0040
`define MTR_OFF_CWR_LO    16'h0088
`define MTR_OFF_CWR_HI    16'h008C

`define MTR_CTRL_ENABLE_BIT 0
`define MTR_CTRL_RESET      1'h0
`define MTR_CWR_RESET       15'h0000
`define MTR_CWR_LSB         5
`define MTR_CWR_MSB         19

// Identification fields; product, variant, revision and implementer are arbitrary
`define MTR_PRODUCT_CODE  8'h5A
`define MTR_VARIANT       4'h1
`define MTR_REVISION      4'h2
`define MTR_CONT_CODE     4'h0
`define MTR_MAKER_CODE    7'h11

`endif

// ### mtr_pkg.sv
// Types shared by the translation front end.
// Assumes nothing beyond the configuration header.
package mtr_pkg;
  typedef logic [31:0] mtr_word_type;
  // One-hot access width of a register write
  typedef enum logic [1:0] {
    MTR_SZ32 = 2'h1,
    MTR_SZ16 = 2'h2
  } mtr_size_type;
endpackage

// ### mtr_req_model.sv
// Requesting-device model: every register and translate access.
// Assumes calls start at a falling edge; strobes stay up until rel.
`timescale 1ns/1ps
module mtr_req_model (
  input  wire logic             sys_clk,
  output logic                  reg_wr,
  output logic                  reg_rd,
  output logic [15:0]           reg_addr,
  output mtr_pkg::mtr_size_type reg_size,
  output logic [31:0]           reg_wdata,
  output logic [31:0]           requester_tag
);
  // One access per call, held over one rising edge
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic h, input logic [31:0] t);
    reg_wr        = w;
    reg_rd        = ~w;
    reg_addr      = a;
    reg_wdata     = d;
    reg_size      = h ? mtr_pkg::MTR_SZ16 : mtr_pkg::MTR_SZ32;
    requester_tag = t; // Fabric-given, one per device
    @(negedge sys_clk);
  endtask
  // Released strobes clear and address, data and tag invert so a stale value never looks valid
  task automatic rel();
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reg_addr      = ~reg_addr;
    reg_wdata     = ~reg_wdata;
    requester_tag = ~requester_tag;
  endtask
  // Quiet bus at time zero
  initial begin
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reg_addr      = 16'h0000;
    reg_size      = mtr_pkg::MTR_SZ32;
    reg_wdata     = 32'h0000_0000;
    requester_tag = 32'h0000_0000;
  end
endmodule

// ### msi_translation_regs_tb_top.sv
// Self-checking bench of the translation register front end.
// Assumes 4 requester and 4 event bits and the map port as sole mapper.
`timescale 1ns/1ps
`include "mtr_cfg.svh"
module msi_translation_regs_tb_top;
  logic                  sys_clk, rst_n, reg_wr, reg_rd, reg_rvalid;
  logic [15:0]           reg_addr;
  mtr_pkg::mtr_size_type reg_size;
  logic [31:0]           reg_wdata, requester_tag, reg_rdata, xlate_event;
  logic                  map_dev_wr, map_dev_valid, map_evt_wr, map_evt_valid;
  logic [3:0]            map_dev_id, map_evt_dev, map_evt_id, xlate_requester;
  logic [4:0]            map_dev_range_m1;
  logic                  xlate_valid, xlate_drop, service_enabled, en;
  logic                  dv[16];
  logic [4:0]            rng[16];
  logic                  em[16][16];
  logic [31:0]           rq[$];
  logic [38:0]           xq[$];
  logic [38:0]           xe;
  int                    err_count, samples_checked;
  localparam logic [31:0] ID_W = {`MTR_PRODUCT_CODE, 4'h0, `MTR_VARIANT, `MTR_REVISION,
                                  `MTR_CONT_CODE, 1'b0, `MTR_MAKER_CODE};
  localparam logic [31:0] FT_L = {8'h04, 4'h0, 1'b0, 1'b0, 5'd3, 5'd3, 4'h7, 4'h1};

  mtr_translation_regs #(.DEV_BITS(4), .EVT_BITS(4)) u_mtr_translation_regs (
    .sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_size, .reg_wdata, .requester_tag,
    .reg_rdata, .reg_rvalid, .map_dev_wr, .map_dev_id, .map_dev_valid, .map_dev_range_m1,
    .map_evt_wr, .map_evt_dev, .map_evt_id, .map_evt_valid, .xlate_valid,
    .xlate_requester, .xlate_event, .xlate_drop, .service_enabled);
  mtr_req_model u_mtr_req_model (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_size,
    .reg_wdata, .requester_tag);

  task automatic check(input logic [37:0] seen, input logic [37:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    map_dev_wr = 1'b0;
    map_evt_wr = 1'b0;
    rq.push_back(e);
    u_mtr_req_model.acc(1'b0, a, 32'h0, 1'b0, 32'h0);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    map_dev_wr = 1'b0;
    map_evt_wr = 1'b0;
    if (a == `MTR_OFF_CONTROL) en = d[0];
    u_mtr_req_model.acc(1'b1, a, d, 1'b0, 32'h0);
  endtask
  // Expected outcome worked out from the drop conditions
  task automatic xl(input logic [31:0] t, input logic [31:0] d, input logic h);
    logic [31:0] ev;
    logic        ok;
    map_dev_wr = 1'b0;
    map_evt_wr = 1'b0;
    ev = h ? {16'h0000, d[15:0]} : d;
    ok = en && t < 32'h10 && dv[t[3:0]] && ev < 32'h10 &&
         ev < (32'h1 << (rng[t[3:0]] + 5'd1)) && em[t[3:0]][ev[3:0]];
    xq.push_back({t < 32'h10, ok, ~ok, t[3:0], ev});
    u_mtr_req_model.acc(1'b1, `MTR_OFF_TRANSLATE, d, h, t);
  endtask
  task automatic map_dev_cmd(input logic [3:0] id, input logic v, input logic [4:0] r);
    u_mtr_req_model.rel();
    map_evt_wr = 1'b0;
    {map_dev_wr, map_dev_id, map_dev_valid, map_dev_range_m1} = {1'b1, id, v, r};
    dv[id] = v;
    rng[id] = r;
    for (int i = 0; i < 16; i++) em[id][i] = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic map_evt_cmd(input logic [3:0] id, input logic [3:0] e, input logic v);
    u_mtr_req_model.rel();
    map_dev_wr = 1'b0;
    {map_evt_wr, map_evt_dev, map_evt_id, map_evt_valid} = {1'b1, id, e, v};
    em[id][e] = v;
    @(negedge sys_clk);
  endtask
  task automatic idle();
    u_mtr_req_model.rel();
    map_dev_wr = 1'b0;
    map_evt_wr = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic stop_test();
    check(38'(rq.size() + xq.size()), 38'h0);
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Clock, 20 ns period
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Each result takes the oldest note of its kind
  always @(negedge sys_clk) begin
    if (reg_rvalid === 1'b1) begin
      check(38'(rq.size() != 0), 38'h1);
      check({6'h0, reg_rdata}, {6'h0, rq.pop_front()});
    end
    if (xlate_valid === 1'b1 || xlate_drop === 1'b1) begin
      check(38'(xq.size() != 0), 38'h1);
      xe = xq.pop_front();
      if (xe[38]) begin
        check({xlate_valid, xlate_drop, xlate_requester, xlate_event}, xe[37:0]);
      end else begin
        check({36'h0, xlate_valid, xlate_drop}, {36'h0, xe[37:36]});
      end
    end
  end
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #400000;
    err_count++;
    stop_test();
  end
  initial begin
    {rst_n, en, map_dev_wr, map_dev_id, map_dev_valid, map_dev_range_m1} = '0;
    {map_evt_wr, map_evt_dev, map_evt_id, map_evt_valid} = '0;
    for (int i = 0; i < 16; i++) begin
      dv[i] = 1'b0;
      rng[i] = 5'h0;
    end
    void'($urandom(12716));
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    check({37'h0, service_enabled}, 38'h0);
    rd(`MTR_OFF_CONTROL, 32'h0);
    for (int k = 0; k < 2; k++) begin
      rd(`MTR_OFF_IMPL_ID, ID_W);
      rd(`MTR_OFF_FEAT_LO, FT_L);
      rd(`MTR_OFF_FEAT_HI, 32'h0000_0013);
      wr(`MTR_OFF_IMPL_ID, 32'hFFFF_FFFF);
      wr(`MTR_OFF_FEAT_LO, 32'hFFFF_FFFF);
      wr(`MTR_OFF_FEAT_HI, 32'hFFFF_FFFF);
    end
    rd(`MTR_OFF_CWR_LO, 32'h0);
    wr(`MTR_OFF_CWR_LO, 32'hFFFF_FFFF);
    wr(`MTR_OFF_CWR_HI, 32'hFFFF_FFFF);
    rd(`MTR_OFF_CWR_LO, 32'h000F_FFE0);
    rd(`MTR_OFF_CWR_HI, 32'h0);
    rd(`MTR_OFF_TRANSLATE, 32'h0);
    rd(16'h0100, 32'h0);
    idle();
    $display("test registers done");
    map_dev_cmd(4'h1, 1'b1, 5'd3);
    map_evt_cmd(4'h1, 4'h3, 1'b1);
    map_dev_cmd(4'h3, 1'b1, 5'd1);
    map_evt_cmd(4'h3, 4'h5, 1'b1);
    xl(32'h1, 32'h3, 1'b0);
    wr(`MTR_OFF_CONTROL, 32'h1);
    rd(`MTR_OFF_CONTROL, 32'h1);
    xl(32'h1, 32'h3, 1'b0);
    xl(32'h1, 32'hABCD_0003, 1'b1);
    xl(32'h1, 32'h0001_0003, 1'b0);
    xl(32'h2, 32'h3, 1'b0);
    xl(32'h10, 32'h3, 1'b0);
    xl(32'h3, 32'h5, 1'b0);
    xl(32'h1, 32'h4, 1'b0);
    idle();
    check({37'h0, service_enabled}, 38'h1);
    wr(`MTR_OFF_CONTROL, 32'h0);
    xl(32'h1, 32'h3, 1'b0);
    wr(`MTR_OFF_CONTROL, 32'h1);
    idle();
    $display("test directed translate done");
    for (int i = 0; i < 8; i++) map_dev_cmd(4'(i), 1'($urandom), 5'($urandom % 5));
    for (int i = 0; i < 40; i++) map_evt_cmd(4'($urandom), 4'($urandom), 1'($urandom));
    for (int i = 0; i < 80; i++) xl($urandom % 18, $urandom % 40, 1'($urandom));
    idle();
    repeat (3) @(negedge sys_clk);
    $display("test random translate done");
    // Mid-run reset must leave every requester unmapped and the service off
    rst_n = 1'b0;
    en = 1'b0;
    for (int i = 0; i < 16; i++) dv[i] = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    check({37'h0, service_enabled}, 38'h0);
    rd(`MTR_OFF_CWR_LO, 32'h0);
    wr(`MTR_OFF_CONTROL, 32'h1);
    xl(32'h1, 32'h3, 1'b0);
    idle();
    repeat (3) @(negedge sys_clk);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
